// >>> src/smed_pkg.sv
// Constants and types for the servo mode, enable and direction block.
// Assumes a single 100 MHz clock domain and synchronous active-high reset.
package smed_pkg;
  localparam logic [3:0] SMED_MODE_SPEED = 4'h0;
  localparam logic [3:0] SMED_MODE_POSITION = 4'h1;
  localparam logic [3:0] SMED_MODE_TORQUE = 4'h2;
  localparam logic [3:0] SMED_MODE_PRESET = 4'h3;
  localparam logic [3:0] SMED_MODE_SW_FIRST = 4'h4;
  localparam logic [3:0] SMED_MODE_SW_LAST = 4'hb;
  localparam logic [3:0] SMED_MODE_MOTION = 4'hc;
  localparam logic [3:0] SMED_SRC_TERM_ONE = 4'h1;
  localparam logic [3:0] SMED_SRC_TERM_FIVE = 4'h5;
  localparam logic [3:0] SMED_SRC_FORCED = 4'h9;

  // Register map
  localparam logic [3:0] SMED_ADDR_CFG = 4'h0;
  localparam logic [3:0] SMED_ADDR_STATUS = 4'h1;
  localparam logic [3:0] SMED_ADDR_IRQ_STAT = 4'h2;
  localparam logic [3:0] SMED_ADDR_IRQ_MASK = 4'h3;
  localparam logic [3:0] SMED_ADDR_PRESET0 = 4'h4;
  localparam logic [3:0] SMED_ADDR_PRESET1 = 4'h5;
  localparam logic [3:0] SMED_ADDR_PRESET2 = 4'h6;
  // CFG fields
  localparam int SMED_CFG_DIR_BIT = 0;
  localparam int SMED_CFG_MODE_LSB = 4;
  localparam int SMED_CFG_SRC_LSB = 8;
  localparam logic [31:0] SMED_CFG_RESET = 32'h0000_0100;
  localparam logic [15:0] SMED_PRESET_RESET = 16'h0000;
  // Interrupt status bits
  localparam int SMED_IRQ_SERVO_ON = 0;
  localparam int SMED_IRQ_SERVO_OFF = 1;
  localparam int SMED_IRQ_FWD_LIMIT = 2;
  localparam int SMED_IRQ_REV_LIMIT = 3;
  localparam int SMED_IRQ_ALARM = 4;
  localparam int SMED_IRQ_W = 5;

  typedef enum logic [4:0] {
    SMED_CTL_SPEED = 5'b00001,
    SMED_CTL_POSITION = 5'b00010,
    SMED_CTL_TORQUE = 5'b00100,
    SMED_CTL_PRESET = 5'b01000,
    SMED_CTL_MOTION = 5'b10000
  } smed_ctl_t;
endpackage

// >>> src/smed_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pin inputs.
// Assumes inputs are levels held far longer than a clock period.
`timescale 1ns/1ps
module smed_sync #(
  parameter int W = 1
) (
  input wire logic clock, // System clock
  input wire logic reset, // Synchronous reset
  input wire logic [W-1:0] async_in, // Raw pin levels
  input wire logic [W-1:0] reset_val, // Level held during reset
  output logic [W-1:0] sync_out // Synchronised levels
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      // Idle levels, so no false pin edge or servo-on pulse follows reset
      meta_q <= reset_val;
      sync_out <= reset_val;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// >>> src/smed_top.sv
// Servo axis mode selection, servo-on gating and direction mapping.
// Assumes pins are asynchronous; registers reached over a simple strobe port.
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module smed_top
  import smed_pkg::*;
#(
  parameter int SPEED_W = 16
) (
  input wire logic clock, // 100 MHz clock
  input wire logic reset, // Sync reset, models power-up
  input wire logic [3:0] reg_addr, // Register word address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_write, // Write strobe
  input wire logic reg_read, // Read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  input wire logic axis_select, // 0 first axis, 1 second axis
  input wire logic input_terminal_one, // Servo-on pin, active low
  input wire logic input_terminal_five, // Servo-on pin, active low
  input wire logic positive_travel_limit, // High prohibits positive side
  input wire logic negative_travel_limit, // High prohibits negative side
  input wire logic proportional_select_in, // Preset select bit 0
  input wire logic forward_limit_current_in, // Preset select bit 1
  input wire logic reverse_limit_current_in, // Preset select bit 2
  input wire logic mode_switch_in, // Switching-mode select pin
  input wire logic alarm_in, // Alarm condition, level
  input wire logic alarm_reset_in, // Alarm reset pin, active high
  input wire logic ref_positive, // Reference polarity is positive
  input wire logic ref_active, // A nonzero motion reference present
  output logic motor_energize, // Motor energised
  output logic [4:0] ctl_mode, // One-hot active loop
  output logic [SPEED_W-1:0] preset_speed, // Selected internal speed
  output logic rotate_ccw, // Physical rotation counterclockwise
  output logic motion_permit, // Reference may drive motor
  output logic alarm_latched, // Alarm held
  output logic irq // Level interrupt
);
  localparam int PIN_W = 10;

  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_s;
  logic son_one_n, son_five_n, pos_lim, neg_lim, sel0, sel1, sel2, sw_s, alm_s, almrst_s;

  assign pins_raw = {input_terminal_one, input_terminal_five, positive_travel_limit,
                     negative_travel_limit, proportional_select_in, forward_limit_current_in,
                     reverse_limit_current_in, mode_switch_in, alarm_in, alarm_reset_in};

  smed_sync #(.W(PIN_W)) u_sync (
    .clock(clock),
    .reset(reset),
    .async_in(pins_raw),
    .reset_val(10'h300),
    .sync_out(pins_s)
  );

  assign {son_one_n, son_five_n, pos_lim, neg_lim, sel0, sel1, sel2, sw_s, alm_s, almrst_s} =
    pins_s;

  // Software-visible configuration
  logic [31:0] cfg_q;
  logic [SPEED_W-1:0] preset_q [3];
  logic [SMED_IRQ_W-1:0] irq_stat_q, irq_mask_q;
  logic [3:0] src_q;
  logic src_loaded_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      cfg_q <= SMED_CFG_RESET;
    end else if (reg_write && reg_addr == SMED_ADDR_CFG) begin
      cfg_q <= reg_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < 3; i++) begin
        preset_q[i] <= SMED_PRESET_RESET;
      end
    end else if (reg_write && reg_addr >= SMED_ADDR_PRESET0 && reg_addr <= SMED_ADDR_PRESET2)
    begin
      preset_q[2'(reg_addr - SMED_ADDR_PRESET0)] <= reg_wdata[SPEED_W-1:0];
    end
  end

  // Source setting captured once after reset, from the CFG reset value; later writes never reach it
  always_ff @(posedge clock) begin
    if (reset) begin
      src_q <= 4'h0;
      src_loaded_q <= 1'b0;
    end else if (!src_loaded_q) begin
      src_q <= cfg_q[SMED_CFG_SRC_LSB +: 4];
      src_loaded_q <= 1'b1;
    end
  end

  logic [3:0] mode_dig;
  logic dir_rev;
  assign mode_dig = cfg_q[SMED_CFG_MODE_LSB +: 4];
  assign dir_rev = cfg_q[SMED_CFG_DIR_BIT];

  // Servo-on routing
  logic forced_on, son_active;
  assign forced_on = src_loaded_q && (src_q == SMED_SRC_FORCED);
  always_comb begin
    son_active = 1'b0;
    if (src_loaded_q) begin
      case (src_q)
        SMED_SRC_TERM_ONE: son_active = !son_one_n;
        SMED_SRC_TERM_FIVE: son_active = !son_five_n;
        SMED_SRC_FORCED: son_active = 1'b1;
        default: son_active = axis_select ? !son_five_n : !son_one_n;
      endcase
    end
  end

  // Alarm latch; reset input ignored while forced on
  always_ff @(posedge clock) begin
    if (reset) begin
      alarm_latched <= 1'b0;
    end else if (alm_s) begin
      alarm_latched <= 1'b1;
    end else if (almrst_s && !forced_on) begin
      alarm_latched <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      motor_energize <= 1'b0;
    end else begin
      motor_energize <= son_active && !alarm_latched;
    end
  end

  // Mode decode
  function automatic smed_ctl_t smed_basic(input logic [3:0] d);
    case (d)
      SMED_MODE_SPEED: return SMED_CTL_SPEED;
      SMED_MODE_POSITION: return SMED_CTL_POSITION;
      SMED_MODE_TORQUE: return SMED_CTL_TORQUE;
      SMED_MODE_PRESET: return SMED_CTL_PRESET;
      SMED_MODE_MOTION: return SMED_CTL_MOTION;
      default: return SMED_CTL_SPEED;
    endcase
  endfunction

  // Switching modes pair two basic modes; the pin picks which one runs
  function automatic logic [7:0] smed_pair(input logic [3:0] d);
    case (d)
      4'h4: return {4'h3, 4'h0};
      4'h5: return {4'h3, 4'h1};
      4'h6: return {4'h3, 4'h2};
      4'h7: return {4'h0, 4'h1};
      4'h8: return {4'h0, 4'h2};
      4'h9: return {4'h1, 4'h2};
      4'ha: return {4'h1, 4'h0};
      4'hb: return {4'h2, 4'h0};
      default: return {d, d};
    endcase
  endfunction

  smed_ctl_t ctl_d;
  logic [7:0] pair;
  always_comb begin
    pair = smed_pair(mode_dig);
    if (mode_dig >= SMED_MODE_SW_FIRST && mode_dig <= SMED_MODE_SW_LAST) begin
      ctl_d = smed_basic(sw_s ? pair[7:4] : pair[3:0]);
    end else begin
      ctl_d = smed_basic(mode_dig);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ctl_mode <= SMED_CTL_SPEED;
    end else begin
      ctl_mode <= ctl_d;
    end
  end

  // Fixed one-hot decode of preset selects; others give zero speed
  always_ff @(posedge clock) begin
    if (reset) begin
      preset_speed <= '0;
    end else if (ctl_d != SMED_CTL_PRESET) begin
      preset_speed <= '0;
    end else begin
      case ({sel2, sel1, sel0})
        3'b001: preset_speed <= preset_q[0];
        3'b010: preset_speed <= preset_q[1];
        3'b100: preset_speed <= preset_q[2];
        default: preset_speed <= '0;
      endcase
    end
  end

  // Direction and overtravel; encoder and monitor outputs are not touched here
  logic ccw_d, pos_blocked, neg_blocked, guard_hit;
  assign ccw_d = ref_positive ^ dir_rev;
  assign pos_blocked = pos_lim;
  assign neg_blocked = neg_lim;
  // Positive limit guards CCW when dir 0, CW when dir 1
  assign guard_hit = (ccw_d ^ dir_rev) ? pos_blocked : neg_blocked;

  always_ff @(posedge clock) begin
    if (reset) begin
      rotate_ccw <= 1'b0;
      motion_permit <= 1'b0;
    end else begin
      rotate_ccw <= ccw_d;
      motion_permit <= ref_active && son_active && !alarm_latched && !guard_hit;
    end
  end

  // Interrupts: set wins over write-one-to-clear
  logic son_prev_q, pos_prev_q, neg_prev_q, alm_prev_q;
  logic [SMED_IRQ_W-1:0] irq_set;
  always_ff @(posedge clock) begin
    if (reset) begin
      son_prev_q <= 1'b0;
      pos_prev_q <= 1'b0;
      neg_prev_q <= 1'b0;
      alm_prev_q <= 1'b0;
    end else begin
      son_prev_q <= motor_energize;
      pos_prev_q <= pos_lim;
      neg_prev_q <= neg_lim;
      alm_prev_q <= alarm_latched;
    end
  end

  always_comb begin
    irq_set = '0;
    irq_set[SMED_IRQ_SERVO_ON] = motor_energize && !son_prev_q;
    irq_set[SMED_IRQ_SERVO_OFF] = !motor_energize && son_prev_q;
    irq_set[SMED_IRQ_FWD_LIMIT] = pos_lim && !pos_prev_q;
    irq_set[SMED_IRQ_REV_LIMIT] = neg_lim && !neg_prev_q;
    irq_set[SMED_IRQ_ALARM] = alarm_latched && !alm_prev_q;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      irq_stat_q <= '0;
    end else begin
      if (reg_write && reg_addr == SMED_ADDR_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~reg_wdata[SMED_IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat_q <= irq_stat_q | irq_set;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      irq_mask_q <= '0;
    end else if (reg_write && reg_addr == SMED_ADDR_IRQ_MASK) begin
      irq_mask_q <= reg_wdata[SMED_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // Read port; unmapped addresses read zero
  always_ff @(posedge clock) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_read) begin
      case (reg_addr)
        SMED_ADDR_CFG: reg_rdata <= cfg_q;
        SMED_ADDR_STATUS: reg_rdata <= {18'h00000, src_q, 1'b0, ctl_mode, alarm_latched,
                                        neg_lim, pos_lim, motor_energize};
        SMED_ADDR_IRQ_STAT: reg_rdata <= 32'(irq_stat_q);
        SMED_ADDR_IRQ_MASK: reg_rdata <= 32'(irq_mask_q);
        SMED_ADDR_PRESET0: reg_rdata <= 32'(preset_q[0]);
        SMED_ADDR_PRESET1: reg_rdata <= 32'(preset_q[1]);
        SMED_ADDR_PRESET2: reg_rdata <= 32'(preset_q[2]);
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule

// >>> sim/smed_ctrl_model.sv
// Command controller model for the far side of the servo axis.
// Assumes the bench requests motion with run and picks polarity with dir_pos.
`timescale 1ns/1ps
module smed_ctrl_model (
  input wire logic clock, // Clock
  input wire logic run, // Motion wanted
  input wire logic dir_pos, // Wanted polarity
  output logic servo_on_n, // Servo-on, active low
  output logic ref_active, // Reference present
  output logic ref_positive // Reference polarity
);
  logic [3:0] cnt_q = 4'h0;
  initial begin
    servo_on_n = 1'b1;
    ref_active = 1'b0;
    ref_positive = 1'b1;
  end
  // Servo-on settles before commands and is dropped only after them
  always @(posedge clock) begin
    ref_positive <= dir_pos;
    cnt_q <= (run == ref_active && run != servo_on_n) ? 4'h0 : cnt_q + 4'h1;
    if (run) begin
      servo_on_n <= 1'b0;
      if (cnt_q == 4'h8) ref_active <= 1'b1;
    end else begin
      ref_active <= 1'b0;
      if (cnt_q == 4'h8) servo_on_n <= 1'b1;
    end
  end
endmodule

// >>> sim/smed_checker.sv
// Port assertions for the servo mode, enable and direction block.
// Assumes source digit 1 after reset; pins reach outputs in three edges.
`timescale 1ns/1ps
module smed_checker #(
  parameter int SPEED_W = 16
) (
  input wire logic clock, // Clock
  input wire logic reset, // Reset
  input wire logic reg_write, // Write strobe
  input wire logic input_terminal_one, // Servo-on pin
  input wire logic positive_travel_limit, // Limit pin
  input wire logic negative_travel_limit, // Limit pin
  input wire logic alarm_in, // Alarm pin
  input wire logic ref_positive, // Polarity
  input wire logic motor_energize, // Energised
  input wire logic [4:0] ctl_mode, // Loop
  input wire logic [SPEED_W-1:0] preset_speed, // Preset
  input wire logic rotate_ccw, // Rotation
  input wire logic motion_permit, // Permit
  input wire logic alarm_latched // Alarm
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  AST_MODE_ONEHOT: assert property ($onehot(ctl_mode)) else $error("mode");
  AST_PRESET_ZERO: assert property (preset_speed != '0 |-> ctl_mode == 5'h08) else $error("p");
  AST_SERVO_OFF: assert property (input_terminal_one [*4] |=> !motor_energize) else $error("s");
  AST_PERMIT_ON: assert property (motion_permit |-> motor_energize) else $error("e");
  AST_ALARM_SET: assert property (alarm_in [*4] |=> alarm_latched) else $error("a");
  AST_ALARM_BLOCK: assert property (alarm_latched [*2] |-> !motion_permit) else $error("b");
  AST_DIR_FLIP: assert property (!reg_write && !$past(reg_write) && $changed(ref_positive)
    |=> $changed(rotate_ccw)) else $error("d");
  AST_LIMIT_BOTH: assert property ((positive_travel_limit && negative_travel_limit) [*4]
    |=> !motion_permit) else $error("l");
  C_ON: cover property ($rose(motor_energize));
  C_PRESET: cover property (preset_speed != '0);
  C_ALARM: cover property ($rose(alarm_latched));
endmodule
bind smed_top smed_checker #(.SPEED_W(SPEED_W)) smed_checker_i (.clock(clock), .reset(reset),
  .reg_write(reg_write), .input_terminal_one(input_terminal_one),
  .positive_travel_limit(positive_travel_limit), .negative_travel_limit(negative_travel_limit),
  .alarm_in(alarm_in), .ref_positive(ref_positive), .motor_energize(motor_energize),
  .ctl_mode(ctl_mode), .preset_speed(preset_speed), .rotate_ccw(rotate_ccw),
  .motion_permit(motion_permit), .alarm_latched(alarm_latched));

// >>> sim/smed_top_tb.sv
// Self-checking bench for the servo mode, enable and direction block.
// Assumes the bound checker and the controller model on the servo-on pin.
`timescale 1ns/1ps
`define CHK(g, e) check_val(32'(g), 32'(e))
module smed_top_tb;
  import smed_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic reg_write = 1'b0, reg_read = 1'b0, run = 1'b0, dir_pos = 1'b1, a;
  logic pos_lim = 1'b0, neg_lim = 1'b0, msw = 1'b0, alarm = 1'b0, alarm_rst = 1'b0;
  logic [2:0] psel = 3'h0;
  logic [4:0] mode;
  logic [15:0] speed;
  logic son_n, ref_act, ref_pos, energize, ccw, permit, alarm_q, irq;
  int mismatches = 0, total_checks = 0;
  always #5 clock = ~clock;
  smed_ctrl_model smed_ctrl_model_i (.clock(clock), .run(run), .dir_pos(dir_pos),
    .servo_on_n(son_n), .ref_active(ref_act), .ref_positive(ref_pos));
  smed_top #(.SPEED_W(16)) smed_top_i (.clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .axis_select(1'b0), .input_terminal_one(son_n), .input_terminal_five(1'b1),
    .positive_travel_limit(pos_lim), .negative_travel_limit(neg_lim),
    .proportional_select_in(psel[0]), .forward_limit_current_in(psel[1]),
    .reverse_limit_current_in(psel[2]), .mode_switch_in(msw), .alarm_in(alarm),
    .alarm_reset_in(alarm_rst), .ref_positive(ref_pos), .ref_active(ref_act),
    .motor_energize(energize), .ctl_mode(mode), .preset_speed(speed), .rotate_ccw(ccw),
    .motion_permit(permit), .alarm_latched(alarm_q), .irq(irq));
  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [3:0] ad, input logic [31:0] wd);
    @(posedge clock);
    reg_addr <= ad;
    reg_wdata <= wd;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] ad);
    @(posedge clock);
    reg_addr <= ad;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic t_servo;
    rd(SMED_ADDR_CFG);
    `CHK(d, SMED_CFG_RESET);
    rd(4'hf);
    `CHK(d, 32'h0);
    run <= 1'b1;
    cyc(20);
    `CHK(energize, 1'b1);
    rd(SMED_ADDR_IRQ_STAT);
    `CHK(d, 32'h1);
    wr(SMED_ADDR_IRQ_MASK, 32'h0);
    cyc(1);
    a = irq;
    wr(SMED_ADDR_IRQ_MASK, 32'h1f);
    cyc(1);
    `CHK(a ^ irq, 1'b1);
    wr(SMED_ADDR_IRQ_STAT, 32'h1);
    cyc(1);
    `CHK(irq, 1'b0);
    run <= 1'b0;
    cyc(20);
    `CHK(energize, 1'b0);
    rd(SMED_ADDR_IRQ_STAT);
    `CHK(d, 32'h2);
    wr(SMED_ADDR_IRQ_STAT, 32'h1f);
    $display("servo done");
  endtask
  task automatic t_modes;
    logic [3:0] dg[5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hc};
    logic [4:0] ex[5] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
    logic [2:0] sl[5] = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h0};
    logic [15:0] sp[5] = '{16'h11, 16'h22, 16'h33, 16'h0, 16'h0};
    for (int i = 0; i < 5; i++) begin
      wr(SMED_ADDR_CFG, {20'h1, dg[i], 4'h0});
      cyc(3);
      `CHK(mode, ex[i]);
    end
    wr(SMED_ADDR_CFG, 32'h140);
    msw <= 1'b1;
    cyc(5);
    `CHK(mode, SMED_CTL_PRESET);
    msw <= 1'b0;
    wr(SMED_ADDR_PRESET0, 32'h11);
    wr(SMED_ADDR_PRESET1, 32'h22);
    wr(SMED_ADDR_PRESET2, 32'h33);
    wr(SMED_ADDR_CFG, 32'h130);
    for (int i = 0; i < 5; i++) begin
      psel <= sl[i];
      cyc(5);
      `CHK(speed, sp[i]);
    end
    psel <= 3'h1;
    wr(SMED_ADDR_CFG, 32'h100);
    cyc(5);
    `CHK(speed, 16'h0);
    psel <= 3'h0;
    $display("modes done");
  endtask
  task automatic t_dir;
    run <= 1'b1;
    cyc(20);
    `CHK(ccw, 1'b1);
    `CHK(permit, 1'b1);
    pos_lim <= 1'b1;
    cyc(5);
    `CHK(permit, 1'b0);
    dir_pos <= 1'b0;
    cyc(4);
    `CHK(ccw, 1'b0);
    `CHK(permit, 1'b1);
    wr(SMED_ADDR_CFG, 32'h101);
    cyc(3);
    `CHK(ccw, 1'b1);
    `CHK(permit, 1'b1);
    dir_pos <= 1'b1;
    cyc(4);
    `CHK(permit, 1'b0);
    neg_lim <= 1'b1;
    dir_pos <= 1'b0;
    cyc(6);
    `CHK(permit, 1'b0);
    pos_lim <= 1'b0;
    neg_lim <= 1'b0;
    cyc(5);
    `CHK(permit, 1'b1);
    wr(SMED_ADDR_CFG, 32'h100);
    alarm <= 1'b1;
    cyc(5);
    alarm <= 1'b0;
    cyc(5);
    `CHK(alarm_q, 1'b1);
    `CHK(permit, 1'b0);
    alarm_rst <= 1'b1;
    cyc(5);
    alarm_rst <= 1'b0;
    `CHK(alarm_q, 1'b0);
    $display("direction done");
  endtask
  task automatic t_source;
    wr(SMED_ADDR_CFG, 32'h500);
    run <= 1'b0;
    cyc(20);
    rd(SMED_ADDR_STATUS);
    `CHK(d[13:10], 4'h1);
    run <= 1'b1;
    cyc(20);
    `CHK(energize, 1'b1);
    $display("source done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    cyc(12);
    reset <= 1'b0;
    t_servo;
    t_modes;
    t_dir;
    t_source;
    final_report;
  end
  initial begin
    cyc(20000);
    mismatches++;
    final_report;
  end
endmodule
